// [core/bri_boot_ctrl.sv]
// Purpose: Boot mode reader, reset sequencer and interrupt input merge
// Assumes: aclk stands in for the master clock, pins are asynchronous
// Notes: Registers reached over AXI4-Lite; one level interrupt output
`timescale 1ns/1ps
// Contract
// - OR six interrupt pins into bits 5:0
// - OR nmi pin into interrupt bit 6
// - Power-good assertion starts boot stream read
// - Warm reset: reset without cold reset
// - Mode clock is clock divided by 256
// - Mode bit 11 disables timer interrupt
// - Multiplier from mode bits 7:5, 7 reserved
// - Interrupt and reset pins are active low
module bri_boot_ctrl
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Board pins, active low except power-good, mode data and the mode clock output
	input wire logic power_good,
	input wire logic cold_reset_n,
	input wire logic reset_n,
	input wire logic [bri_pkg::INT_GEN_W-1:0] int_n,
	input wire logic nmi_n,
	input wire logic boot_mode_data,
	output logic boot_mode_clk,
	// Core side
	input wire logic timer_irq,
	output logic core_reset_n,
	output logic warm_reset,
	output logic [3:0] pclk_mult,
	output logic [bri_pkg::INT_W-1:0] int_lines,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt
	output logic irq
);
	import bri_pkg::*;

	// Pin synchroniser bundle
	bri_sync_if pins ();
	bri_pin_sync u_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.pins(pins)
	);
	assign pins.raw = {boot_mode_data, int_n, nmi_n, reset_n, cold_reset_n, power_good};

	// Clean level taps
	wire pg_s = pins.clean[0];
	wire pg_rise = pins.changed[0] && pins.clean[0];
	wire cold_act = !pins.clean[1];
	wire rst_act = !pins.clean[2];
	wire nmi_act = !pins.clean[3];
	wire [INT_GEN_W-1:0] int_act = ~pins.clean[9:4];
	wire mode_bit = pins.clean[10];
	wire rst_rise = pins.changed[2] && rst_act;

	// Sequencer state and mode capture
	bri_state_t state;
	bri_state_t next_state;
	logic [7:0] div_cnt; // Mode clock divider
	logic [7:0] bit_cnt; // Stream position
	logic [15:0] mode_lo; // Bits 15:0 kept
	logic bad_stream; // Reserved bit violated
	logic [INT_W-1:0] soft_int; // Software interrupt bits
	logic [EV_W-1:0] ev_status;
	logic [EV_W-1:0] ev_mask;
	logic nmi_d;
	logic timer_en_ovr; // Software override reads back

	// Divider wraps every 256 cycles
	wire div_last = (div_cnt == MODE_LAST);
	// Sample at the divider wrap, as the mode clock falls, half a period after the source moved
	wire sample_en = (state == BRI_READ) && div_last;
	wire stream_done = sample_en && (bit_cnt == MODE_LAST_BIT);
	wire [2:0] mul_code = mode_lo[MB_MUL_HI:MB_MUL_LO];
	// check fixed bits of the stream
	wire bit_bad = (bit_cnt == 8'h00 && mode_bit) ||
		(bit_cnt == 8'h0c && !mode_bit) ||
		(bit_cnt > 8'h0e && mode_bit);

	// Next state
	always_comb
	begin
		next_state = state;
		unique case (state)
			BRI_IDLE:
				if (pg_rise)
					next_state = BRI_READ;
			BRI_READ:
				if (!pg_s)
					next_state = BRI_IDLE;
				else if (stream_done)
					next_state = BRI_HOLD;
			// wait for both resets to release
			BRI_HOLD:
				if (!pg_s)
					next_state = BRI_IDLE;
				else if (!cold_act && !rst_act)
					next_state = BRI_RUN;
			BRI_RUN:
				if (!pg_s)
					next_state = BRI_IDLE;
				else if (cold_act)
					next_state = BRI_HOLD;
				else if (rst_act)
					next_state = BRI_HOLD;
		endcase
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state <= BRI_IDLE;
		else
			state <= next_state;
	end

	// divide by 256, half high half low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_cnt <= 8'h00;
			boot_mode_clk <= 1'b0;
		end
		else
		begin
			div_cnt <= div_cnt + 8'h01;
			boot_mode_clk <= (div_cnt >= MODE_HALF) && !div_last;
		end
	end

	// shift in one bit per mode clock period
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bit_cnt <= 8'h00;
			mode_lo <= 16'h0000;
			bad_stream <= 1'b0;
		end
		else if (state == BRI_IDLE)
		begin
			bit_cnt <= 8'h00;
			if (pg_rise)
				bad_stream <= 1'b0;
		end
		else if (sample_en)
		begin
			bit_cnt <= bit_cnt + 8'h01;
			if (bit_cnt < 8'h10)
				mode_lo[bit_cnt[3:0]] <= mode_bit;
			if (bit_bad)
				bad_stream <= 1'b1;
		end
	end

	// Core reset and multiplier outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_reset_n <= 1'b0;
			warm_reset <= 1'b0;
			pclk_mult <= MUL_BASE;
			int_lines <= '0;
			nmi_d <= 1'b0;
		end
		else
		begin
			core_reset_n <= (next_state == BRI_RUN);
			// warm reset: reset without cold reset
			if (rst_rise && !cold_act && state == BRI_RUN)
				warm_reset <= 1'b1;
			else if (cold_act)
				warm_reset <= 1'b0;
			// reserved code keeps the previous factor
			if (mul_code != MUL_RESERVED)
				pclk_mult <= MUL_BASE + {1'b0, mul_code};
			// general pins OR register, timer gated
			int_lines[INT_GEN_W-1:0] <= int_act | soft_int[INT_GEN_W-1:0] |
				({INT_GEN_W{timer_irq && !mode_lo[MB_TIMER_DIS] && timer_en_ovr}} &
				(6'h01 << INT_TIMER_BIT));
			int_lines[INT_NMI_BIT] <= nmi_act | soft_int[INT_NMI_BIT];
			nmi_d <= nmi_act;
		end
	end

	// Events raised this cycle
	wire [EV_W-1:0] ev_set = {nmi_act && !nmi_d, rst_rise && !cold_act,
		stream_done && (bad_stream || bit_bad), stream_done};

	// Bus decode
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic w_data_lane; // Byte lane zero seen with the data word
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire wr_soft = do_write && aw_addr == REG_SOFT_INT;
	wire wr_mask = do_write && aw_addr == REG_MASK;
	wire wr_timer = do_write && aw_addr == REG_TIMER;
	wire wr_ok = wr_soft || wr_mask || wr_timer;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rd_event = rd_take && s_axi_araddr == REG_EVENT;
	wire rd_hit = s_axi_araddr == REG_INT || s_axi_araddr == REG_SOFT_INT ||
		s_axi_araddr == REG_MODE || s_axi_araddr == REG_STATUS ||
		s_axi_araddr == REG_EVENT || s_axi_araddr == REG_MASK ||
		s_axi_araddr == REG_TIMER;
	wire [31:0] rd_mux =
		(s_axi_araddr == REG_INT) ? {25'h0, int_lines} :
		(s_axi_araddr == REG_SOFT_INT) ? {25'h0, soft_int} :
		(s_axi_araddr == REG_MODE) ? {16'h0, mode_lo} :
		(s_axi_araddr == REG_STATUS) ? {24'h0, bad_stream, core_reset_n,
			pg_s, !cold_act, !rst_act, 1'b0, state} :
		(s_axi_araddr == REG_EVENT) ? {28'h0, ev_status} :
		(s_axi_araddr == REG_MASK) ? {28'h0, ev_mask} :
		(s_axi_araddr == REG_TIMER) ? {31'h0, timer_en_ovr} : 32'h0;

	// Write channel capture and response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Writable registers, low byte lane only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			soft_int <= '0;
			ev_mask <= '0;
			timer_en_ovr <= 1'b1;
		end
		else
		begin
			if (wr_soft && w_data_lane)
				soft_int <= w_data[INT_W-1:0];
			if (wr_mask && w_data_lane)
				ev_mask <= w_data[EV_W-1:0];
			if (wr_timer && w_data_lane)
				timer_en_ovr <= w_data[0];
		end
	end
	// Byte lane zero captured with the data word
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			w_data_lane <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
			w_data_lane <= s_axi_wstrb[0];
	end

	// Sticky events, set wins over clear on read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ev_status <= '0;
		else if (rd_event)
			ev_status <= ev_set;
		else
			ev_status <= ev_status | ev_set;
	end

	// Read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
			irq <= 1'b0;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_take)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
			irq <= |((rd_event ? ev_set : (ev_status | ev_set)) & ev_mask);
		end
	end
endmodule // bri_boot_ctrl

// [core/bri_pkg.sv]
// Purpose: Shared constants for the boot, reset and interrupt input block
// Assumes: Single clock aclk at 125 MHz, AXI4-Lite register access
// Notes: Offsets are byte addresses of aligned 32-bit words
package bri_pkg;
	// Clock and mode clock divider
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned MODE_DIV = 256;
	localparam logic [7:0] MODE_HALF = 8'h7f;
	localparam logic [7:0] MODE_LAST = 8'hff;
	// Boot stream length and mode fields
	localparam int unsigned MODE_BITS = 256;
	localparam logic [7:0] MODE_LAST_BIT = 8'hff;
	localparam int unsigned MB_TIMER_DIS = 11;
	localparam int unsigned MB_MUST_ONE = 12;
	localparam int unsigned MB_MUL_LO = 5;
	localparam int unsigned MB_MUL_HI = 7;
	localparam logic [2:0] MUL_RESERVED = 3'h7;
	localparam logic [3:0] MUL_BASE = 4'h2;
	// Interrupt register layout
	localparam int unsigned INT_GEN_W = 6;
	localparam int unsigned INT_NMI_BIT = 6;
	localparam int unsigned INT_TIMER_BIT = 5;
	localparam int unsigned INT_W = 7;
	// Register byte offsets
	localparam logic [7:0] REG_INT = 8'h00;
	localparam logic [7:0] REG_SOFT_INT = 8'h04;
	localparam logic [7:0] REG_MODE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_EVENT = 8'h10;
	localparam logic [7:0] REG_MASK = 8'h14;
	localparam logic [7:0] REG_TIMER = 8'h18;
	// Event bits
	localparam int unsigned EV_BOOT_DONE = 0;
	localparam int unsigned EV_BAD_STREAM = 1;
	localparam int unsigned EV_WARM = 2;
	localparam int unsigned EV_NMI = 3;
	localparam int unsigned EV_W = 4;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Boot sequencer states
	typedef enum logic [1:0]
	{
		BRI_IDLE = 2'b00,
		BRI_READ = 2'b01,
		BRI_HOLD = 2'b10,
		BRI_RUN = 2'b11
	} bri_state_t;
endpackage

// [core/bri_sync_if.sv]
// Purpose: Carries raw pins into the synchroniser and clean levels out
// Assumes: All pins are asynchronous to aclk
// Notes: Pin order is power-good, cold reset, reset, nmi, int[5:0], mode data
`timescale 1ns/1ps
interface bri_sync_if;
	// Raw pin levels
	logic [10:0] raw;
	// Filtered levels
	logic [10:0] clean;
	// Pulse when a filtered level changes
	logic [10:0] changed;
	modport sync
	(
		input raw,
		output clean,
		output changed
	);
	modport user
	(
		output raw,
		input clean,
		input changed
	);
endinterface // bri_sync_if

// [core/bri_pin_sync.sv]
// Purpose: Three-stage pin synchroniser with agree filter
// Assumes: Inputs come from outside the aclk domain
// Notes: A change counts only once stages two and three agree
`timescale 1ns/1ps
module bri_pin_sync
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pin bundle
	bri_sync_if.sync pins
);
	import bri_pkg::*;

	genvar gi;
	generate
		for (gi = 0; gi < 11; gi++)
		begin : g_bit
			// First stage feeds only the second
			logic s1;
			logic s2;
			logic s3;
			logic held;
			logic chg;
			// Power-good idles low, every other pin idles high; no false edge after reset
			localparam logic IDLE_LVL = (gi == 0) ? 1'b0 : 1'b1;
			// Shift chain, reset to the pin's idle level
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					s1 <= IDLE_LVL;
					s2 <= IDLE_LVL;
					s3 <= IDLE_LVL;
					held <= IDLE_LVL;
					chg <= 1'b0;
				end
				else
				begin
					s1 <= pins.raw[gi];
					s2 <= s1;
					s3 <= s2;
					// Accept only when the two later stages agree
					chg <= (s2 == s3) && (s3 != held);
					if (s2 == s3)
						held <= s3;
				end
			end
			assign pins.clean[gi] = held;
			assign pins.changed[gi] = chg;
		end
	endgenerate
endmodule // bri_pin_sync

// [testbench/bri_chk_assertions.sv]
// Purpose: Port checks for the boot, reset and interrupt block
// Assumes: One clock; pins settle through a short filter
// Notes: Eight-cycle windows cover the filter latency
`timescale 1ns/1ps
module bri_chk
	import bri_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Board pins
	input wire logic power_good,
	input wire logic cold_reset_n,
	input wire logic reset_n,
	input wire logic [bri_pkg::INT_GEN_W-1:0] int_n,
	input wire logic nmi_n,
	// Block outputs
	input wire logic boot_mode_clk,
	input wire logic core_reset_n,
	input wire logic warm_reset,
	input wire logic [3:0] pclk_mult,
	input wire logic [bri_pkg::INT_W-1:0] int_lines
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_int_gen;
		$stable(int_n)[*8] |-> (~int_n & ~int_lines[5:0]) == 6'h00;
	endproperty
	a_int_gen: assert property (p_int_gen) else $error("pin missing from lines");
	property p_nmi;
		(!nmi_n)[*8] |-> int_lines[INT_NMI_BIT];
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi missing from lines");
	property p_mclk_period;
		$rose(boot_mode_clk) |-> ##256 $rose(boot_mode_clk);
	endproperty
	a_mclk_period: assert property (p_mclk_period) else $error("mode clock period");
	property p_mclk_high;
		$rose(boot_mode_clk) |-> boot_mode_clk[*8];
	endproperty
	a_mclk_high: assert property (p_mclk_high) else $error("mode clock glitch");
	property p_core_hold;
		(!cold_reset_n)[*8] |-> !core_reset_n;
	endproperty
	a_core_hold: assert property (p_core_hold) else $error("core ran in cold reset");
	property p_core_release;
		$rose(core_reset_n) |-> power_good && cold_reset_n && reset_n;
	endproperty
	a_core_release: assert property (p_core_release) else $error("early core release");
	property p_warm;
		$rose(warm_reset) |-> cold_reset_n && !reset_n;
	endproperty
	a_warm: assert property (p_warm) else $error("warm reset without cause");
	property p_mult;
		pclk_mult >= 4'h2 && pclk_mult <= 4'h8;
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier out of range");
	c_boot: cover property ($rose(core_reset_n));
	c_warm: cover property ($rose(warm_reset));
	c_nmi: cover property (int_lines[INT_NMI_BIT]);
endmodule // bri_chk
bind bri_boot_ctrl bri_chk u_chk (.aclk, .aresetn, .power_good, .cold_reset_n, .reset_n,
	.int_n, .nmi_n, .boot_mode_clk, .core_reset_n, .warm_reset, .pclk_mult, .int_lines);

// [testbench/bri_boot_src.sv]
// Purpose: Board boot source shifting mode bits out
// Assumes: Frame starts at a mode clock rise with power-good
// Notes: Off frame the line toggles, never a stale bit
`timescale 1ns/1ps
module bri_boot_src
(
	// Board side
	input wire logic power_good,
	input wire logic boot_mode_clk,
	input wire logic [15:0] mode_word,
	output logic boot_mode_data
);
	// Stream bit index
	logic [8:0] idx = 9'h000;
	always @(posedge boot_mode_clk)
		idx <= power_good ? idx + 9'h001 : 9'h000;
	assign boot_mode_data = (!power_good || idx[8]) ? boot_mode_clk :
		(idx < 9'h010 ? mode_word[idx[3:0]] : 1'b0);
endmodule // bri_boot_src

// [testbench/boot_reset_interrupt_inputs_tb.sv]
// Purpose: Scenario bench for the boot, reset and interrupt block
// Assumes: One boot only, a stream takes 65536 cycles
// Notes: Pins change on clock edges by non-blocking assignment
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module boot_reset_interrupt_inputs_tb;
	import bri_pkg::*;
	// Pins; both resets low at power on
	logic aclk = 1'b0, aresetn = 1'b0, power_good = 1'b0, cold_reset_n = 1'b0;
	logic reset_n = 1'b0, nmi_n = 1'b1, timer_irq = 1'b0, boot_mode_data;
	logic [5:0] int_n = 6'h3f;
	logic boot_mode_clk, core_reset_n, warm_reset, irq;
	logic [3:0] pclk_mult;
	logic [6:0] int_lines;
	// Register bus
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int errors = 0, n_tests = 0;
	// Timer off, multiplier code 5, bit 12 set
	localparam logic [15:0] MODE_WORD = 16'h18a0;
	bri_boot_ctrl dut (.aclk, .aresetn, .power_good, .cold_reset_n, .reset_n, .int_n, .nmi_n,
		.boot_mode_data, .boot_mode_clk, .timer_irq, .core_reset_n, .warm_reset, .pclk_mult,
		.int_lines, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq);
	bri_boot_src src (.power_good, .boot_mode_clk, .mode_word(MODE_WORD), .boot_mode_data);
	// 125 MHz clock
	initial forever #4 aclk = ~aclk;
	task final_report;
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// A wait ran out
	task stall;
		errors++;
		final_report();
	endtask
	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Write; both channels offered together
	task axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 50)
			stall();
	endtask
	task axr(input logic [7:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 50)
			stall();
	endtask
	// Next mode clock rise
	task mclk_rise;
		int i;
		logic p;
		p = boot_mode_clk;
		for (i = 0; i < 300; i++)
		begin
			@(posedge aclk);
			if (boot_mode_clk && !p)
				break;
			p = boot_mode_clk;
		end
		if (i == 300)
			stall();
	endtask
	task t_reset;
		time t0;
		`CHK("core held", 1'b0, core_reset_n)
		mclk_rise();
		t0 = $time;
		mclk_rise();
		`CHK("mode period", 64'd2048, $time - t0)
	endtask
	// Each pin alone, then soft bit 6
	task t_ints;
		int b;
		for (b = 0; b < 7; b++)
		begin
			int_n <= ~(6'h01 << b);
			nmi_n <= (b != 6);
			tick(8);
			`CHK("int lines", 7'h01 << b, int_lines)
		end
		int_n <= 6'h3f;
		nmi_n <= 1'b1;
		axw(REG_SOFT_INT, 32'h40);
		tick(8);
		`CHK("soft nmi", 7'h40, int_lines)
		axr(REG_INT);
		`CHK("int reg", 32'h40, rd)
		axw(REG_SOFT_INT, 32'h0);
		// Mode bit 11 still clear before boot: timer reaches bit 5
		timer_irq <= 1'b1;
		tick(3);
		`CHK("timer on", 7'h20, int_lines)
		axw(REG_TIMER, 32'h0);
		tick(3);
		`CHK("timer gated", 7'h00, int_lines)
		timer_irq <= 1'b0;
		axw(REG_TIMER, 32'h1);
		// Lane zero off: the word must not land
		s_axi_wstrb <= 4'h0;
		axw(REG_SOFT_INT, 32'h7f);
		s_axi_wstrb <= 4'hf;
		axr(REG_SOFT_INT);
		`CHK("strobe gate", 32'h0, rd)
		axw(8'h40, 32'h0);
		`CHK("unmapped write", RESP_SLVERR, rsp)
		axr(REG_EVENT);
	endtask
	// Stream read under cold reset
	task t_boot;
		int i;
		mclk_rise();
		power_good <= 1'b1;
		for (i = 0; i < 300; i++)
		begin
			tick(256);
			axr(REG_STATUS);
			if (rd[1:0] === BRI_HOLD)
				break;
		end
		if (i == 300)
			stall();
		`CHK("boot done", BRI_HOLD, rd[1:0])
		`CHK("held by pins", 1'b0, core_reset_n)
		cold_reset_n <= 1'b1;
		tick(20);
		`CHK("held by reset", 1'b0, core_reset_n)
		reset_n <= 1'b1;
		for (i = 0; i < 50 && core_reset_n !== 1'b1; i++)
			tick(1);
		if (i == 50)
			stall();
		`CHK("core run", 1'b1, core_reset_n)
		`CHK("mult", 4'h7, pclk_mult)
		axr(REG_MODE);
		`CHK("mode bits", {16'h0, MODE_WORD}, rd)
		timer_irq <= 1'b1;
		tick(8);
		`CHK("timer off", 1'b0, int_lines[5])
		timer_irq <= 1'b0;
	endtask
	// Mask steers irq; read clears
	task t_irq;
		axw(REG_MASK, 32'h1);
		tick(3);
		`CHK("irq unmasked", 1'b1, irq)
		axw(REG_MASK, 32'h0);
		tick(3);
		`CHK("irq masked", 1'b0, irq)
		// Unmask again so the clear on read is what drops irq
		axw(REG_MASK, 32'h1);
		axr(REG_EVENT);
		`CHK("events", 32'h1, rd)
		tick(3);
		`CHK("irq clear", 1'b0, irq)
		axr(8'h40);
		`CHK("unmapped", RESP_SLVERR, rsp)
	endtask
	task t_warm;
		int i;
		reset_n <= 1'b0;
		for (i = 0; i < 50 && warm_reset !== 1'b1; i++)
			tick(1);
		if (i == 50)
			stall();
		`CHK("warm", 1'b1, warm_reset)
		reset_n <= 1'b1;
		tick(10);
		cold_reset_n <= 1'b0;
		tick(8);
		`CHK("warm cleared", 1'b0, warm_reset)
		`CHK("core held", 1'b0, core_reset_n)
	endtask
	initial
	begin
		tick(6);
		aresetn <= 1'b1;
		tick(1);
		t_reset();
		t_ints();
		t_boot();
		t_irq();
		t_warm();
		final_report();
	end
endmodule // boot_reset_interrupt_inputs_tb
